// file: aps_pkg.sv
// Package of constants and types for the address pin and switch sensing block.
package aps_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SENSE_PERIOD_US = 1024;
    localparam int unsigned DEBOUNCE_US = 32;
    localparam int unsigned FLOAT_HOLD_MS = 64;
    localparam int unsigned SENSE_PERIOD_CYC = SENSE_PERIOD_US * (CLK_HZ / 1000000);
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
    localparam int unsigned FLOAT_HOLD_CYC = FLOAT_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned HALF_PERIOD_CYC = SENSE_PERIOD_CYC / 2;

    localparam int CNT_W = 22;
    localparam int POS_W = 16;
    localparam int ADDR_W = 7;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_POS = 32'h0000_0004;
    localparam logic [31:0] ADDR_FRAME = 32'h0000_0008;
    localparam logic [31:0] ADDR_STATE = 32'h0000_000C;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SECACK_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        APS_FLOAT,
        APS_LOW,
        APS_HIGH
    } aps_pin_state_t;

    typedef enum logic [1:0] {
        APS_IDLE,
        APS_BOT,
        APS_TOP
    } aps_phase_t;
endpackage : aps_pkg

// file: aps_sync_debounce.sv
// Debouncer for the sense comparator during one strobe window.
`timescale 1ns/1ns
`default_nettype none
module aps_sync_debounce (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic window,
    input wire logic raw,
    output logic stable_ff,
    output logic done_ff
);
    import aps_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic last_ff;

    // The value must stay constant for the whole debounce time in the window.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            last_ff <= 1'b0;
            stable_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            last_ff <= raw;
            if (!window || raw != last_ff) begin
                cnt_ff <= '0;
            end else if (cnt_ff == CNT_W'(DEBOUNCE_CYC - 1)) begin
                cnt_ff <= cnt_ff + 1'b1;
                stable_ff <= raw;
                done_ff <= 1'b1;
            end else if (cnt_ff < CNT_W'(DEBOUNCE_CYC)) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule : aps_sync_debounce
`default_nettype wire

// file: aps_sense_top.sv
// Address pin and switch sensing with a position snapshot and an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Top and bottom sense switches are strobed alternately and never together.
// - Each strobe repeats every 1024 us.
// - The comparator is debounced 32 us before use, and the block sequences the switches.
// - A bottom sample of 1 goes High; a 0 turns High into Float, else the state stays.
// - A top sample of 1 goes Low; a 0 turns Low into Float, else the state stays.
// - The next state depends only on previous state, active strobe and debounced value.
// - High reports address bit 1, Low bit 0, and Float is a separate output.
// - Float held for 64 ms starts a secure-position motion; shorter episodes do not.
// - The switch uses the same scheme with two states, open giving 0 and closed 1.
// - The switch flag changes only in step with a sense strobe.
// - When the switch debouncer completes within a sense pulse, the switch flag and position are captured together.
// - Read-back byte 1 is switch flag and node address, bytes 2 and 3 the position.
// - Read-back byte 4 holds the six status flags then the two-bit temperature field.
module aps_sense_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sense_comparator_out,
    input wire logic switch_comparator_out,
    input wire logic [aps_pkg::POS_W-1:0] actual_position,
    input wire logic [5:0] node_address_low,
    input wire logic [5:0] status_flags,
    input wire logic [1:0] temperature_info,
    output logic high_side_sense_strobe,
    output logic low_side_sense_strobe,
    output logic address_bit,
    output logic address_floating,
    output logic secure_position_start,
    output logic switch_closed_flag
);
    import aps_pkg::*;

    logic [CNT_W-1:0] period_cnt_ff;
    aps_phase_t phase_ff;
    aps_pin_state_t pin_state_ff;
    aps_pin_state_t nxt_pin_state;
    logic [CNT_W-1:0] float_cnt_ff;
    logic secure_done_ff;
    logic [POS_W-1:0] snap_pos_ff;
    logic snap_sw_ff;
    logic [31:0] ctrl_ff;
    logic addr_dbc;
    logic addr_done;
    logic sw_dbc;
    logic sw_done;
    logic strobe_on;
    logic wr_pend_ff;
    logic [31:0] wr_addr_ff;
    logic [31:0] frame;

    assign strobe_on = (phase_ff != APS_IDLE);

    // One counter spaces the bottom and top strobes half a period apart.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_cnt_ff <= '0;
            phase_ff <= APS_IDLE;
            high_side_sense_strobe <= 1'b0;
            low_side_sense_strobe <= 1'b0;
        end else if (!ctrl_ff[CTRL_EN_BIT]) begin
            period_cnt_ff <= '0;
            phase_ff <= APS_IDLE;
            high_side_sense_strobe <= 1'b0;
            low_side_sense_strobe <= 1'b0;
        end else begin
            if (period_cnt_ff == CNT_W'(SENSE_PERIOD_CYC - 1)) begin
                period_cnt_ff <= '0;
            end else begin
                period_cnt_ff <= period_cnt_ff + 1'b1;
            end
            case (phase_ff)
                APS_IDLE: begin
                    if (period_cnt_ff == '0) begin
                        phase_ff <= APS_BOT;
                        low_side_sense_strobe <= 1'b1;
                    end else if (period_cnt_ff == CNT_W'(HALF_PERIOD_CYC)) begin
                        phase_ff <= APS_TOP;
                        high_side_sense_strobe <= 1'b1;
                    end
                end
                APS_BOT, APS_TOP: begin
                    // The strobe ends when debouncing has produced its sample.
                    if (addr_done) begin
                        phase_ff <= APS_IDLE;
                        high_side_sense_strobe <= 1'b0;
                        low_side_sense_strobe <= 1'b0;
                    end
                end
                default: begin
                    phase_ff <= APS_IDLE;
                    high_side_sense_strobe <= 1'b0;
                    low_side_sense_strobe <= 1'b0;
                end
            endcase
        end
    end

    aps_sync_debounce u_addr_dbc (
        .hclk(hclk),
        .hresetn(hresetn),
        .window(strobe_on),
        .raw(sense_comparator_out),
        .stable_ff(addr_dbc),
        .done_ff(addr_done)
    );

    aps_sync_debounce u_sw_dbc (
        .hclk(hclk),
        .hresetn(hresetn),
        .window(strobe_on),
        .raw(switch_comparator_out),
        .stable_ff(sw_dbc),
        .done_ff(sw_done)
    );

    always_comb begin
        nxt_pin_state = pin_state_ff;
        if (phase_ff == APS_BOT) begin
            if (addr_dbc) begin
                nxt_pin_state = APS_HIGH;
            end else if (pin_state_ff == APS_HIGH) begin
                nxt_pin_state = APS_FLOAT;
            end
        end else if (phase_ff == APS_TOP) begin
            if (addr_dbc) begin
                nxt_pin_state = APS_LOW;
            end else if (pin_state_ff == APS_LOW) begin
                nxt_pin_state = APS_FLOAT;
            end
        end
    end

    // The debounced value is registered, so the state moves one cycle after the done pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_state_ff <= APS_FLOAT;
            address_bit <= 1'b0;
            address_floating <= 1'b1;
        end else begin
            if (addr_done) begin
                pin_state_ff <= nxt_pin_state;
                address_bit <= (nxt_pin_state == APS_HIGH);
                address_floating <= (nxt_pin_state == APS_FLOAT);
            end
        end
    end

    // Float must persist 64 ms; micro-interruptions reset the count and fire nothing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            float_cnt_ff <= '0;
            secure_done_ff <= 1'b0;
            secure_position_start <= 1'b0;
        end else begin
            secure_position_start <= 1'b0;
            if (pin_state_ff != APS_FLOAT || ctrl_ff[CTRL_SECACK_BIT]) begin
                float_cnt_ff <= '0;
                secure_done_ff <= 1'b0;
            end else if (!secure_done_ff) begin
                if (float_cnt_ff == CNT_W'(FLOAT_HOLD_CYC - 1)) begin
                    secure_done_ff <= 1'b1;
                    secure_position_start <= 1'b1;
                end else begin
                    float_cnt_ff <= float_cnt_ff + 1'b1;
                end
            end
        end
    end

    // Switch flag and position are latched on the same edge for a coherent read-back.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            switch_closed_flag <= 1'b0;
            snap_sw_ff <= 1'b0;
            snap_pos_ff <= '0;
        end else if (sw_done) begin
            switch_closed_flag <= sw_dbc;
            snap_sw_ff <= sw_dbc;
            snap_pos_ff <= actual_position;
        end
    end

    // The node address pairs the sensed pin bit with the low address bits.
    assign frame = {snap_sw_ff, address_bit, node_address_low, snap_pos_ff, status_flags, temperature_info};

    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads give zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_ff <= 1'b0;
            if (hsel && hready && htrans == HTRANS_NONSEQ) begin
                wr_pend_ff <= hwrite;
                wr_addr_ff <= haddr;
                if (!hwrite) begin
                    case (haddr)
                        ADDR_CTRL: hrdata <= ctrl_ff;
                        ADDR_POS: hrdata <= {15'h0000, snap_sw_ff, snap_pos_ff};
                        ADDR_FRAME: hrdata <= frame;
                        ADDR_STATE: hrdata <= {27'h0000000, secure_done_ff, address_floating,
                                               address_bit, pin_state_ff};
                        default: hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_pend_ff && wr_addr_ff == ADDR_CTRL) begin
            ctrl_ff <= {30'h00000000, hwdata[CTRL_SECACK_BIT], hwdata[CTRL_EN_BIT]};
        end
    end
endmodule : aps_sense_top
`default_nettype wire

// file: aps_sense_checker.sv
// Checker of the sense strobe sequence and address state outputs.
`timescale 1ns/1ns
`default_nettype none
module aps_sense_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic sense_comparator_out,
    input wire logic switch_comparator_out,
    input wire logic high_side_sense_strobe,
    input wire logic low_side_sense_strobe,
    input wire logic address_bit,
    input wire logic address_floating,
    input wire logic secure_position_start,
    input wire logic switch_closed_flag
);
    logic any_s;
    logic ls_q_ff;
    logic seen_ff;
    logic [16:0] gap_ff;
    logic [15:0] hi_ff;
    assign any_s = high_side_sense_strobe | low_side_sense_strobe;
    // Cycles since the last bottom strobe began.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_q_ff <= 1'b0;
            seen_ff <= 1'b0;
            gap_ff <= 17'h0;
        end else begin
            ls_q_ff <= low_side_sense_strobe;
            seen_ff <= seen_ff | (low_side_sense_strobe & ~ls_q_ff);
            gap_ff <= (low_side_sense_strobe & ~ls_q_ff) ? 17'h1 : gap_ff + 17'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_ff <= 16'h0;
        end else begin
            hi_ff <= any_s ? hi_ff + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    strobe_excl_a: assert property (!(high_side_sense_strobe && low_side_sense_strobe))
        else $error("Both sense strobes are high.");
    bottom_period_a: assert property (low_side_sense_strobe && !ls_q_ff && seen_ff |-> gap_ff == 17'h0C800)
        else $error("Bottom strobe period is wrong.");
    top_offset_a: assert property ($rose(high_side_sense_strobe) && seen_ff |-> gap_ff == 17'h06400)
        else $error("Top strobe offset is wrong.");
    debounce_len_a: assert property ($fell(any_s) |-> hi_ff >= 16'h063F)
        else $error("Strobe ended before the debounce time.");
    bottom_high_a: assert property ($fell(low_side_sense_strobe) && $past(sense_comparator_out)
        |-> ##[0:2] address_bit && !address_floating) else $error("Bottom sample did not give High.");
    top_low_a: assert property ($fell(high_side_sense_strobe) && $past(sense_comparator_out)
        |-> ##[0:2] !address_bit && !address_floating) else $error("Top sample did not give Low.");
    bit_float_a: assert property (address_bit |-> !address_floating)
        else $error("Address bit set while floating.");
    secure_float_a: assert property (secure_position_start |-> address_floating)
        else $error("Secure start without Float.");
    switch_close_a: assert property ($fell(any_s) && $past(switch_comparator_out) |-> ##[0:2] switch_closed_flag)
        else $error("Closed switch not flagged.");
    switch_sync_a: assert property ($changed(switch_closed_flag)
        |-> $past(any_s) || $past(any_s, 2) || $past(any_s, 3)) else $error("Switch flag changed between strobes.");
    reset_state_a: assert property ($rose(hresetn) |-> address_floating && !address_bit && !switch_closed_flag)
        else $error("Wrong state after reset.");
    ready_high_a: assert property (hreadyout) else $error("Bus wait state inserted.");
endmodule : aps_sense_checker
bind aps_sense_top aps_sense_checker u_chk (.hclk, .hresetn, .hreadyout, .sense_comparator_out, .switch_comparator_out,
    .high_side_sense_strobe, .low_side_sense_strobe, .address_bit, .address_floating, .secure_position_start,
    .switch_closed_flag);
`default_nettype wire

// file: aps_pin_model.sv
// Model of the external resistor and switch on the sense pins.
`timescale 1ns/1ns
`default_nettype none
module aps_pin_model (
    input wire logic [1:0] pin_mode,
    input wire logic switch_closed,
    input wire logic high_side_sense_strobe,
    input wire logic low_side_sense_strobe,
    output logic sense_comparator_out,
    output logic switch_comparator_out
);
    // Mode 1 pulls to battery, 2 to ground, 0 open; no current flows outside a strobe.
    assign sense_comparator_out = (low_side_sense_strobe && pin_mode == 2'h1)
        || (high_side_sense_strobe && pin_mode == 2'h2);
    assign switch_comparator_out = switch_closed && (high_side_sense_strobe || low_side_sense_strobe);
endmodule : aps_pin_model
`default_nettype wire

// file: testbench.sv
// Testbench of the address pin and switch sensing block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import aps_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sw, hs, ls, abit, afl, sec, swf, scmp, wcmp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, temp, mode;
    logic [2:0] hsize;
    logic [15:0] pos;
    logic [5:0] node, flags;
    int mismatches, check_count;
    aps_sense_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sense_comparator_out(scmp), .switch_comparator_out(wcmp), .actual_position(pos), .node_address_low(node),
        .status_flags(flags), .temperature_info(temp), .high_side_sense_strobe(hs), .low_side_sense_strobe(ls),
        .address_bit(abit), .address_floating(afl), .secure_position_start(sec), .switch_closed_flag(swf));
    aps_pin_model far (.pin_mode(mode), .switch_closed(sw), .high_side_sense_strobe(hs), .low_side_sense_strobe(ls),
        .sense_comparator_out(scmp), .switch_comparator_out(wcmp));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus
    // Waits for one whole strobe window, then lets the results settle.
    task sample(input logic top);
        int i;
        for (i = 0; i < 60000 && (top ? hs : ls) !== 1'b1; i++) @(posedge hclk);
        chk("strobe start", 32'h1, top ? hs : ls);
        chk("other strobe", 32'h0, top ? ls : hs);
        for (i = 0; i < 4000 && (top ? hs : ls) === 1'b1; i++) @(posedge hclk);
        chk("strobe end", 32'h0, top ? hs : ls);
        repeat (3) @(posedge hclk);
    endtask : sample
    task test_done;
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task t_reset;
        chk("floating", 32'h1, afl);
        chk("switch", 32'h0, swf);
        bus(1'b1, ADDR_CTRL, CTRL_RESET, rd);
        bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
        bus(1'b0, 32'h0000_0010, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrl", CTRL_RESET, rd);
        chk("hresp", 32'h0, hresp);
    endtask : t_reset
    task t_high;
        sample(1'b0);
        pos <= 16'hABCD;
        chk("bit high", 32'h1, abit);
        chk("switch closed", 32'h1, swf);
        bus(1'b0, ADDR_POS, 32'h0, rd);
        chk("snapshot", {15'h0, 1'b1, 16'h1234}, rd);
        bus(1'b0, ADDR_FRAME, 32'h0, rd);
        chk("frame", {2'h3, 6'h2A, 16'h1234, 6'h35, 2'h2}, rd);
    endtask : t_high
    task t_keep;
        mode <= 2'h0;
        sw <= 1'b0;
        sample(1'b1);
        chk("bit kept", 32'h1, abit);
        chk("switch open", 32'h0, swf);
        sample(1'b0);
        chk("float", 32'h1, afl);
        chk("bit float", 32'h0, abit);
        chk("secure", 32'h0, sec);
        bus(1'b0, ADDR_STATE, 32'h0, rd);
        chk("state float", 32'h8, rd);
    endtask : t_keep
    task t_low;
        mode <= 2'h2;
        sw <= 1'b1;
        sample(1'b1);
        chk("low float", 32'h0, afl);
        bus(1'b0, ADDR_STATE, 32'h0, rd);
        chk("state", 32'h1, rd);
        bus(1'b0, ADDR_POS, 32'h0, rd);
        chk("snapshot2", {15'h0, 1'b1, 16'hABCD}, rd);
    endtask : t_low
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        #2000000;
        mismatches++;
        test_done();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        mode = 2'h1;
        sw = 1'b1;
        pos = 16'h1234;
        node = 6'h2A;
        flags = 6'h35;
        temp = 2'h2;
        mismatches = 0;
        check_count = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_high();
        t_keep();
        t_low();
        test_done();
    end
endmodule : testbench
`default_nettype wire
